// ==== shared/iom_pkg.sv ====
package iom_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NSLOT = 8;
  localparam int SLOT_W = 3;
  localparam int IMG_AW = 7;
  localparam int IMG_DEPTH = 128;
  localparam logic [3:0] SLOT_BYTES = 4'h8;
  localparam logic [2:0] LAST_SLOT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // image layout
  localparam logic [6:0] DIAG_HI_ADDR = 7'h00;
  localparam logic [6:0] DIAG_LO_ADDR = 7'h01;
  localparam logic [6:0] IN_DATA_BASE = 7'h02;
  localparam logic [6:0] OUT_DATA_BASE = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // size codes: digital channel count, or analog channel width
  localparam logic [1:0] DIG_CH2 = 2'h0;
  localparam logic [1:0] DIG_CH4 = 2'h1;
  localparam logic [1:0] DIG_CH8 = 2'h2;
  localparam logic [1:0] DIG_CH16 = 2'h3;
  localparam logic [1:0] AN_8B = 2'h0;
  localparam logic [1:0] AN_12B = 2'h1;
  localparam logic [1:0] AN_16B = 2'h2;
  localparam logic [1:0] AN_24B = 2'h3;

  localparam logic [7:0] DIG2_MASK = 8'h03;
  localparam logic [7:0] DIG4_MASK = 8'h0F;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [3:0] BYTES_ONE = 4'h1;
  localparam logic [3:0] BYTES_TWO = 4'h2;
  localparam logic ENDIAN_BIG = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic present;
    logic is_out;
    logic analog;
    logic [1:0] size;
    logic [1:0] nch_m1;
  } iom_desc_t;

  typedef struct packed {
    iom_desc_t desc;
    logic [63:0] data;
  } iom_slot_t;

  typedef struct packed {
    logic en;
    logic [IMG_AW-1:0] addr;
    logic [7:0] data;
  } iom_wr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_IN, ST_OUT, ST_DONE} iom_st_t;

  // log2 of bytes per analog channel
  function automatic logic [1:0] iom_bpc_log2(input logic [1:0] size);
    case (size)
      AN_8B: iom_bpc_log2 = 2'h0;
      AN_24B: iom_bpc_log2 = 2'h2;
      default: iom_bpc_log2 = 2'h1;
    endcase
  endfunction : iom_bpc_log2

endpackage : iom_pkg

// ==== logic/iom_byte_fmt.sv ====
`timescale 1ns/1ps
module iom_byte_fmt import iom_pkg::*; (
  // slot description
  input wire iom_desc_t desc_in,
  input wire logic [2:0] idx_in,
  input wire logic little_endian_in,
  // byte placement
  output logic [3:0] nbytes_out,
  output logic [2:0] pos_out,
  output logic [7:0] mask_out
);

  logic [1:0] lg;
  logic [2:0] bpc_m1;
  logic [2:0] sub;
  logic [5:0] total;

  always_comb
  begin
    lg = iom_bpc_log2(desc_in.size);
    bpc_m1 = 3'((4'h1 << lg) - 4'h1);
    sub = idx_in & bpc_m1;
    total = 6'(({4'h0, desc_in.nch_m1} + 6'h01) << lg);
    nbytes_out = BYTES_ONE;
    pos_out = idx_in;
    mask_out = FULL_MASK;
    if (desc_in.analog)
    begin
      // more than eight bytes of channels do not fit a slot word; the rest is cut
      nbytes_out = (total > 6'(SLOT_BYTES)) ? SLOT_BYTES : total[3:0]; // [RULE6]
      pos_out = ((idx_in >> lg) << lg) | (little_endian_in ? sub : (bpc_m1 - sub)); // [RULE7]
    end
    else
    begin
      if (desc_in.size == DIG_CH16)
      begin
        nbytes_out = BYTES_TWO; // [RULE5]
      end
      case (desc_in.size)
        DIG_CH2: mask_out = DIG2_MASK;
        DIG_CH4: mask_out = DIG4_MASK;
        default: mask_out = FULL_MASK;
      endcase
    end
  end

endmodule : iom_byte_fmt

// ==== logic/iom_img_ram.sv ====
`timescale 1ns/1ps
module iom_img_ram import iom_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // write port
  input wire logic we_in,
  input wire logic [IMG_AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // read port
  input wire logic [IMG_AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem [IMG_DEPTH];
  logic [7:0] rdata_reg;

  // read returns the old byte when the same address is written in that cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= mem[raddr_in];
    end
  end

  assign rdata_out = rdata_reg;

endmodule : iom_img_ram

// ==== logic/iom_mapper.sv ====
// How it works
// RULE1: read image holds inputs plus coupler diagnostics.
// RULE2: master writes outputs; device delivers them.
// RULE3: placement by direction, slot order, size.
// RULE4: active digital channel reads as 1.
// RULE5: digital one bit each; 16 channels two bytes.
// RULE6: analog 1, 2 or 4 bytes per channel; code cuts a module at eight bytes.
// RULE7: analog byte order selectable, big by default.
// RULE8: inputs mapped first, then outputs.
// RULE9: diagnostic word heads the input image.
// RULE10: diagnostic high byte 0, low byte 1.
// RULE11: contiguous ascending slots; output image from 0.
// RULE12: channel 1 in bit 0, unused bits zero.
`timescale 1ns/1ps
module iom_mapper import iom_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // configuration and coupler state
  input wire logic little_endian_in,
  input wire logic [15:0] diag_word_in,
  // module slots
  input wire iom_slot_t [NSLOT-1:0] slot_in,
  output logic [NSLOT-1:0][63:0] slot_out_data_out,
  // master side of the read image
  input wire logic [IMG_AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  // master side of the write image
  input wire iom_wr_t wr_in,
  // status
  output logic [IMG_AW-1:0] in_len_out,
  output logic [IMG_AW-1:0] out_len_out,
  output logic cycle_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    iom_st_t st;
    logic [SLOT_W-1:0] slot;
    logic [2:0] idx;
    logic [IMG_AW-1:0] addr;
    logic pend;
    logic [SLOT_W-1:0] pslot;
    logic [2:0] ppos;
    logic [7:0] pmask;
    logic [IMG_AW-1:0] in_len;
    logic [IMG_AW-1:0] out_len;
    logic done;
    logic [NSLOT-1:0][63:0] out_data;
  } iom_state_t;

  iom_state_t state_reg;
  iom_state_t state_next;

  iom_desc_t cur;
  logic want;
  logic active;
  logic last_byte;
  logic [IMG_AW-1:0] addr_after;
  logic [3:0] fmt_nbytes;
  logic [2:0] fmt_pos;
  logic [7:0] fmt_mask;

  logic rim_we;
  logic [IMG_AW-1:0] rim_addr;
  logic [7:0] rim_wdata;
  logic [7:0] wim_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // byte placement and image stores

  iom_byte_fmt u_fmt (
    .desc_in(cur),
    .idx_in(state_reg.idx),
    .little_endian_in(little_endian_in),
    .nbytes_out(fmt_nbytes),
    .pos_out(fmt_pos),
    .mask_out(fmt_mask)
  );

  iom_img_ram u_read_img (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .we_in(rim_we),
    .waddr_in(rim_addr),
    .wdata_in(rim_wdata),
    .raddr_in(rd_addr_in),
    .rdata_out(rd_data_out)
  );

  // the master owns the write port of the write image
  iom_img_ram u_write_img (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .we_in(wr_in.en),
    .waddr_in(wr_in.addr),
    .wdata_in(wr_in.data),
    .raddr_in(state_reg.addr),
    .rdata_out(wim_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // walk: header, input slots, output slots, then start again

  always_comb
  begin
    cur = slot_in[state_reg.slot].desc;
    want = (state_reg.st == ST_OUT) ? cur.is_out : !cur.is_out; // [RULE3]
    active = cur.present && want;
    last_byte = ({1'b0, state_reg.idx} == (fmt_nbytes - 4'h1));
    addr_after = active ? (state_reg.addr + 7'h01) : state_reg.addr; // [RULE11]
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.pend = 1'b0;
    rim_we = 1'b0;
    rim_addr = state_reg.addr;
    rim_wdata = 8'h00;
    // a byte fetched from the write image lands one cycle later
    if (state_reg.pend)
    begin
      state_next.out_data[state_reg.pslot][{state_reg.ppos, 3'b000} +: 8] = wim_rdata & state_reg.pmask; // [RULE2]
    end
    case (state_reg.st)
      ST_IDLE:
      begin
        state_next.st = ST_HDR;
        state_next.idx = 3'h0;
      end
      ST_HDR:
      begin
        rim_we = 1'b1; // [RULE9]
        rim_addr = state_reg.idx[0] ? DIAG_LO_ADDR : DIAG_HI_ADDR; // [RULE10]
        rim_wdata = state_reg.idx[0] ? diag_word_in[7:0] : diag_word_in[15:8]; // [RULE10]
        state_next.idx = 3'h1;
        if (state_reg.idx[0])
        begin
          state_next.st = ST_IN;
          state_next.slot = '0;
          state_next.idx = 3'h0;
          state_next.addr = IN_DATA_BASE; // [RULE9]
        end
      end
      ST_IN, ST_OUT:
      begin
        if (active && state_reg.st == ST_IN)
        begin
          rim_we = 1'b1; // [RULE1]
          // channel bytes are masked so unused digital bits read zero
          rim_wdata = slot_in[state_reg.slot].data[{fmt_pos, 3'b000} +: 8] & fmt_mask; // [RULE4] [RULE12]
        end
        if (active && state_reg.st == ST_OUT)
        begin
          state_next.pend = 1'b1;
          state_next.pslot = state_reg.slot;
          state_next.ppos = fmt_pos;
          state_next.pmask = fmt_mask; // [RULE12]
        end
        state_next.addr = addr_after;
        state_next.idx = state_reg.idx + 3'h1;
        if (!active || last_byte)
        begin
          state_next.idx = 3'h0;
          state_next.slot = state_reg.slot + 3'h1;
          if (state_reg.slot == LAST_SLOT)
          begin
            state_next.slot = '0;
            if (state_reg.st == ST_IN)
            begin
              state_next.st = ST_OUT; // [RULE8]
              state_next.in_len = addr_after;
              state_next.addr = OUT_DATA_BASE; // [RULE11]
            end
            else
            begin
              state_next.st = ST_DONE;
            end
          end
        end
      end
      ST_DONE:
      begin
        state_next.out_len = state_reg.addr;
        state_next.done = 1'b1;
        state_next.st = ST_HDR;
        state_next.idx = 3'h0;
      end
      default:
      begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign slot_out_data_out = state_reg.out_data;
  assign in_len_out = state_reg.in_len;
  assign out_len_out = state_reg.out_len;
  assign cycle_done_out = state_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_hdr_hi;
    state_reg.st == ST_HDR && state_reg.idx == 3'h0 && rim_we;
  endsequence

  sequence s_hdr_lo;
    state_reg.st == ST_HDR && state_reg.idx == 3'h1 && rim_we;
  endsequence

  sequence s_first_slot;
    state_reg.st == ST_IN && state_reg.slot == 3'h0 && state_reg.addr == IN_DATA_BASE;
  endsequence

  property p_diag_first;
    s_hdr_hi |=> s_hdr_lo ##1 s_first_slot;
  endproperty
  a_diag_first: assert property (p_diag_first) else $error("diagnostic word does not head the input image"); // [RULE9]

  property p_diag_bytes;
    s_hdr_hi |-> rim_addr == 7'h00 && rim_wdata == diag_word_in[15:8]
      ##1 rim_addr == 7'h01 && rim_wdata == diag_word_in[7:0];
  endproperty
  a_diag_bytes: assert property (p_diag_bytes) else $error("diagnostic bytes misplaced"); // [RULE10]

  property p_in_before_out;
    state_reg.st == ST_OUT |=> state_reg.st == ST_OUT || state_reg.st == ST_DONE;
  endproperty
  a_in_before_out: assert property (p_in_before_out) else $error("input mapping after output mapping"); // [RULE8]

  property p_contiguous;
    (rim_we && state_reg.st == ST_IN) ##1 (rim_we && state_reg.st == ST_IN) |-> rim_addr == $past(rim_addr) + 7'h01;
  endproperty
  a_contiguous: assert property (p_contiguous) else $error("gap in input image"); // [RULE11]

  property p_out_base;
    state_reg.st == ST_IN && $past(state_reg.st) == ST_IN ##1 state_reg.st == ST_OUT |-> state_reg.addr == 7'h00;
  endproperty
  a_out_base: assert property (p_out_base) else $error("output image does not start at 0"); // [RULE11]

  property p_dig_mask;
    rim_we && state_reg.st == ST_IN && !cur.analog |-> (rim_wdata & ~fmt_mask) == 8'h00
      && rim_wdata[0] == (state_reg.idx == 3'h0 ? slot_in[state_reg.slot].data[0] : slot_in[state_reg.slot].data[8]);
  endproperty
  a_dig_mask: assert property (p_dig_mask) else $error("digital channel bits misplaced"); // [RULE4] [RULE12]

  property p_dig_size;
    state_reg.st == ST_IN && active && !cur.analog |-> fmt_nbytes == ((cur.size == DIG_CH16) ? 4'h2 : 4'h1);
  endproperty
  a_dig_size: assert property (p_dig_size) else $error("digital module byte count wrong"); // [RULE5]

  property p_an_size;
    state_reg.st == ST_IN && active && cur.analog && cur.nch_m1 == 2'h0 |->
      fmt_nbytes == ((cur.size == AN_8B) ? 4'h1 : (cur.size == AN_24B) ? 4'h4 : 4'h2);
  endproperty
  a_an_size: assert property (p_an_size) else $error("analog channel byte count wrong"); // [RULE6]

  property p_big_endian;
    rim_we && state_reg.st == ST_IN && cur.analog && cur.size == AN_16B && state_reg.idx == 3'h0
      && little_endian_in == ENDIAN_BIG |-> rim_wdata == slot_in[state_reg.slot].data[15:8];
  endproperty
  a_big_endian: assert property (p_big_endian) else $error("big-endian high byte not first"); // [RULE7]

  property p_out_delivery;
    state_reg.pend |=> state_reg.out_data[$past(state_reg.pslot)][{$past(state_reg.ppos), 3'b000} +: 8]
      == ($past(wim_rdata) & $past(state_reg.pmask));
  endproperty
  a_out_delivery: assert property (p_out_delivery) else $error("output byte not delivered"); // [RULE2]

  property p_read_back;
    (rim_we && rim_addr == rd_addr_in) ##1 (rd_addr_in == $past(rd_addr_in) && !(rim_we && rim_addr == rd_addr_in))
      |=> rd_data_out == $past(rim_wdata, 2);
  endproperty
  a_read_back: assert property (p_read_back) else $error("master does not read mapped byte"); // [RULE1]

  property p_out_no_read_write;
    state_reg.st == ST_OUT |-> !rim_we;
  endproperty
  a_out_no_read_write: assert property (p_out_no_read_write) else $error("output module written into read image"); // [RULE3]

  property p_absent_no_bytes;
    (state_reg.st == ST_IN || state_reg.st == ST_OUT) && !cur.present && state_reg.slot != LAST_SLOT
      |=> state_reg.addr == $past(state_reg.addr);
  endproperty
  a_absent_no_bytes: assert property (p_absent_no_bytes) else $error("absent slot took image bytes"); // [RULE11]

endmodule : iom_mapper

// ==== test/iom_master_model.sv ====
`timescale 1ns/1ps
module iom_master_model import iom_pkg::*; (
  // clock
  input wire logic ref_clk_in,
  // read image access
  output logic [IMG_AW-1:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  // write image access
  output iom_wr_t wr_out
);

  initial
  begin
    rd_addr_out = '0;
    wr_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one read: address at a falling edge, data settled by the next one
  task automatic read_byte(input logic [IMG_AW-1:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    rd_addr_out = a;
    @(negedge ref_clk_in);
    d = rd_data_in;
  endtask : read_byte

  // released address and data are inverted so a stale value never looks valid
  task automatic write_byte(input logic [IMG_AW-1:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    wr_out = '{en: 1'b1, addr: a, data: d};
    @(negedge ref_clk_in);
    wr_out = '{en: 1'b0, addr: ~a, data: ~d};
  endtask : write_byte

endmodule : iom_master_model

// ==== test/test_io_process_image_mapper.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_io_process_image_mapper import iom_pkg::*; ;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic little_endian_in = 1'b0;
  logic [15:0] diag_word_in = 16'h0000;
  iom_slot_t [NSLOT-1:0] slot_in = '0;
  logic [NSLOT-1:0][63:0] slot_out_data_out;
  logic [IMG_AW-1:0] rd_addr_in;
  logic [7:0] rd_data_out;
  iom_wr_t wr_in;
  logic [IMG_AW-1:0] in_len_out;
  logic [IMG_AW-1:0] out_len_out;
  logic cycle_done_out;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h7239;
  int cycles = 0;
  logic [7:0] wimg [64];
  logic [NSLOT-1:0][63:0] exp_out = '0;

  iom_mapper dut_u (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .little_endian_in(little_endian_in),
    .diag_word_in(diag_word_in),
    .slot_in(slot_in),
    .slot_out_data_out(slot_out_data_out),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out),
    .wr_in(wr_in),
    .in_len_out(in_len_out),
    .out_len_out(out_len_out),
    .cycle_done_out(cycle_done_out)
  );

  iom_master_model mst_u (
    .ref_clk_in(ref_clk_in),
    .rd_addr_out(rd_addr_in),
    .rd_data_in(rd_data_out),
    .wr_out(wr_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reference model of the byte placement
  function automatic int bpc(iom_desc_t d);
    return d.size == AN_8B ? 1 : (d.size == AN_24B ? 4 : 2);
  endfunction : bpc

  // analog totals above the slot width are cut, as the design does
  function automatic int nbytes(iom_desc_t d);
    if (!d.analog)
      return d.size == DIG_CH16 ? 2 : 1;
    return bpc(d) * (d.nch_m1 + 1) > 8 ? 8 : bpc(d) * (d.nch_m1 + 1);
  endfunction : nbytes

  function automatic int src(iom_desc_t d, int i, bit le);
    int w;
    w = d.analog ? bpc(d) : 1;
    return (i / w) * w + (le ? i % w : w - 1 - i % w);
  endfunction : src

  function automatic logic [7:0] msk(iom_desc_t d);
    if (d.analog || d.size > DIG_CH4)
      return FULL_MASK;
    return d.size == DIG_CH2 ? DIG2_MASK : DIG4_MASK;
  endfunction : msk

  ////////////////////////////////////////////////////////////////////////////
  // closing, timeout and walk tracking
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // eight rounds of five walks and reads stay well under this ceiling
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("Error timeout expected finish seen hang");
      wrap_up();
    end
  end

  task automatic wait_done();
    int n;
    n = 0;
    while (cycle_done_out !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    `CHK("walk done", 1'b1, cycle_done_out)
    @(negedge ref_clk_in);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  // one random configuration, checked after both images have settled
  task automatic run_round(input int r);
    int ip;
    int op;
    int n;
    int b;
    logic [7:0] got;
    iom_desc_t d;
    // a new setup lands just after a walk ends, so no slot changes inside a slot pass
    wait_done();
    little_endian_in = r[0];
    diag_word_in = 16'($random(seed));
    for (int s = 0; s < NSLOT; s++)
    begin
      slot_in[s].desc = 7'($random(seed));
      slot_in[s].data = {$random(seed), $random(seed)};
    end
    wait_done();
    wait_done();
    for (int a = 0; a < 64; a++)
    begin
      wimg[a] = 8'($random(seed));
      mst_u.write_byte(7'(a), wimg[a]);
    end
    // a write landing mid-walk is only sure to be delivered after two walks
    wait_done();
    wait_done();
    mst_u.read_byte(DIAG_HI_ADDR, got);
    `CHK("diag high", diag_word_in[15:8], got)
    mst_u.read_byte(DIAG_LO_ADDR, got);
    `CHK("diag low", diag_word_in[7:0], got)
    ip = 2;
    op = 0;
    for (int s = 0; s < NSLOT; s++)
    begin
      d = slot_in[s].desc;
      if (d.present)
      begin
        n = nbytes(d);
        for (int i = 0; i < n; i++)
        begin
          b = src(d, i, r[0]);
          if (d.is_out)
            exp_out[s][8*b +: 8] = wimg[op + i] & msk(d);
          else
          begin
            mst_u.read_byte(7'(ip + i), got);
            `CHK("read image", slot_in[s].data[8*b +: 8] & msk(d), got)
          end
        end
        if (d.is_out)
          op += n;
        else
          ip += n;
      end
    end
    `CHK("input length", 7'(ip), in_len_out)
    `CHK("output length", 7'(op), out_len_out)
    for (int s = 0; s < NSLOT; s++)
    begin
      if (slot_in[s].desc.present && slot_in[s].desc.is_out)
        `CHK("slot output", exp_out[s], slot_out_data_out[s])
    end
  endtask : run_round

  initial
  begin
    repeat (3) @(negedge ref_clk_in);
    `CHK("reset input length", 7'h00, in_len_out)
    `CHK("reset done", 1'b0, cycle_done_out)
    sys_rst_in = 1'b0;
    // fill the write image first so no walk ever fetches an unwritten byte
    for (int a = 0; a < 64; a++)
      mst_u.write_byte(7'(a), 8'h00);
    for (int r = 0; r < 8; r++)
      run_round(r);
    wrap_up();
  end

endmodule : test_io_process_image_mapper
